/* src/tbl_decoder.sv */
// Transfer and interrupt-table base-load decoder
// Summary of operation
// - The upper 4 base bits come from the second word; the base load is 8 bytes and 4 cycles.
// - The lower 16 base bits come from the last word and sit below the upper field.
// - Generic immediate uses a size bit and 4-bit destination; 3/2 to a register, up to 5/3 to memory.
// - A word-sized generic immediate adds one byte for every destination.
// - Quick form carries a sign-extended 4-bit immediate; 2/1 to a register, up to 4/2 to memory.
// - Short byte immediate uses a 3-bit destination code costing 2/1, 3/2 or 4/2.
// - Short address register immediate has an inverted size bit, one destination bit, 2/1 plus 1/1 for word.
// - Zero form uses the short destination code costing 1/1, 2/2 or 3/2.
// - Short byte load into an address register uses a 2-bit source costing 1/2, 2/3 or 3/3.
// - Short accumulator byte store uses a 2-bit memory destination costing 2/2 or 3/2.
// - Short byte load into an accumulator byte costs 1/2, 2/3 or 3/3 by source.
// - Stack-relative load to any destination costs 3/2 to a register, up to 5/3 to memory.
// - Stack-relative store from any source costs 3/3 from a register, up to 5/4 from memory.
`timescale 1ns/1ps
module tbl_decoder (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 word_valid,
	input  wire logic [15:0]          word_in,
	input  wire tbl_pkg::tbl_req_t    req,
	output tbl_pkg::tbl_resp_t        resp_r,
	output logic                      base_done_r,
	output logic      [19:0]          interrupt_table_base_r,
	output logic      [3:0]           base_bytes_r,
	output logic      [3:0]           base_cycles_r
);

	typedef enum logic [1:0] {BL_IDLE, BL_W1, BL_W2, BL_W3} tbl_bl_state_t;

	tbl_bl_state_t          bl_state_r;
	tbl_bl_state_t          bl_state_nxt;
	logic [3:0]             base_upper_field_r;
	logic [3:0]             base_upper_field_nxt;
	logic                   bl_finish;
	tbl_pkg::tbl_resp_t     resp_nxt;
	tbl_pkg::tbl_opclass_t  dst_cls;
	tbl_pkg::tbl_opclass_t  src_cls;
	logic [3:0]             dst_ext;
	logic [3:0]             src_ext;
	logic                   dst_reg;
	logic                   src_reg;
	logic [2:0]             sdst;
	logic [1:0]             ssrc;
	logic [3:0]             word_upper;

	assign word_upper = word_in[tbl_pkg::BL_UPPER_LSB +: tbl_pkg::BL_UPPER_W];
	assign sdst       = req.dst_code[2:0];
	assign ssrc       = req.src_code[1:0];

	// ----------------------------------------
	// Base-load sequence tracker
	// ----------------------------------------
	// A stray second or third word restarts the match, and a first word there restarts at once; any fourth word is taken as the lower field
	always_comb begin
		bl_state_nxt         = bl_state_r;
		base_upper_field_nxt = base_upper_field_r;
		bl_finish            = 1'b0;
		if (word_valid) begin
			unique case (bl_state_r)
				BL_IDLE: begin
					if (word_in == tbl_pkg::BL_WORD1)
						bl_state_nxt = BL_W1;
				end
				BL_W1: begin
					if (word_in[15:12] == 4'h0 && word_in[7:0] == 8'h00) begin
						bl_state_nxt         = BL_W2;
						base_upper_field_nxt = word_upper;
					end else if (word_in == tbl_pkg::BL_WORD1)
						bl_state_nxt = BL_W1;
					else
						bl_state_nxt = BL_IDLE;
				end
				BL_W2: begin
					if (word_in == tbl_pkg::BL_WORD3)
						bl_state_nxt = BL_W3;
					else if (word_in == tbl_pkg::BL_WORD1)
						bl_state_nxt = BL_W1;
					else
						bl_state_nxt = BL_IDLE;
				end
				BL_W3: begin
					bl_state_nxt = BL_IDLE;
					bl_finish    = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bl_state_r         <= BL_IDLE;
			base_upper_field_r <= 4'h0;
		end else begin
			bl_state_r         <= bl_state_nxt;
			base_upper_field_r <= base_upper_field_nxt;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			base_done_r            <= 1'b0;
			interrupt_table_base_r <= 20'h00000;
			base_bytes_r           <= 4'h0;
			base_cycles_r          <= 4'h0;
		end else begin
			base_done_r <= bl_finish;
			if (bl_finish) begin
				interrupt_table_base_r <= {base_upper_field_r, word_in};
				base_bytes_r           <= tbl_pkg::BL_BYTES;
				base_cycles_r          <= tbl_pkg::BL_CYCLES;
			end
		end
	end

	// ----------------------------------------
	// Operand classification
	// ----------------------------------------
	tbl_opclass u_dst_cls (
		.code      (req.dst_code),
		.op_class  (dst_cls),
		.ext_bytes (dst_ext),
		.is_reg    (dst_reg)
	);

	tbl_opclass u_src_cls (
		.code      (req.src_code),
		.op_class  (src_cls),
		.ext_bytes (src_ext),
		.is_reg    (src_reg)
	);

	// ----------------------------------------
	// Form decode
	// ----------------------------------------
	always_comb begin
		resp_nxt           = '0;
		resp_nxt.valid     = req.valid;
		resp_nxt.dst_code  = req.dst_code;
		resp_nxt.src_code  = req.src_code;
		resp_nxt.size_word = (req.size == tbl_pkg::SIZE_WORD);
		resp_nxt.dst_class = tbl_pkg::OPC_NONE;
		resp_nxt.src_class = tbl_pkg::OPC_NONE;
		unique case (req.form)
			tbl_pkg::FORM_GEN_IMM: begin
				resp_nxt.dst_class = dst_cls;
				resp_nxt.bytes     = tbl_pkg::GIMM_BYTES + dst_ext + {3'h0, resp_nxt.size_word};
				resp_nxt.cycles    = dst_reg ? tbl_pkg::GIMM_CYC_REG : tbl_pkg::GIMM_CYC_MEM;
			end
			tbl_pkg::FORM_QUICK: begin
				resp_nxt.dst_class = dst_cls;
				resp_nxt.bytes     = tbl_pkg::QUICK_BYTES + dst_ext;
				resp_nxt.cycles    = dst_reg ? tbl_pkg::QUICK_CYC_REG : tbl_pkg::QUICK_CYC_MEM;
				// Sign extension stops at the operand size; upper byte stays clear for bytes
				if (resp_nxt.size_word)
					resp_nxt.imm = {{12{req.quick_immediate_field[3]}}, req.quick_immediate_field};
				else
					resp_nxt.imm = {8'h00, {4{req.quick_immediate_field[3]}}, req.quick_immediate_field};
			end
			tbl_pkg::FORM_SHORT_IMM, tbl_pkg::FORM_ZERO: begin
				resp_nxt.size_word = 1'b0;
				unique case (sdst)
					tbl_pkg::SDST_ACC_HIGH, tbl_pkg::SDST_ACC_LOW: begin
						resp_nxt.dst_class = tbl_pkg::OPC_DATA_REG;
						resp_nxt.bytes     = (req.form == tbl_pkg::FORM_ZERO) ? tbl_pkg::ZERO_BYTES : tbl_pkg::SIMM_BYTES;
						resp_nxt.cycles    = (req.form == tbl_pkg::FORM_ZERO) ? tbl_pkg::ZERO_CYC_REG : tbl_pkg::SIMM_CYC_REG;
					end
					tbl_pkg::SDST_SB_DSP8, tbl_pkg::SDST_FB_DSP8, tbl_pkg::SDST_DIRECT_16BIT_OPERAND: begin
						resp_nxt.dst_class = (sdst == tbl_pkg::SDST_DIRECT_16BIT_OPERAND) ? tbl_pkg::OPC_DIRECT_16BIT_OPERAND : tbl_pkg::OPC_DSP8;
						resp_nxt.bytes     = ((req.form == tbl_pkg::FORM_ZERO) ? tbl_pkg::ZERO_BYTES : tbl_pkg::SIMM_BYTES)
							+ ((sdst == tbl_pkg::SDST_DIRECT_16BIT_OPERAND) ? tbl_pkg::EXT_DSP16 : tbl_pkg::EXT_DSP8);
						resp_nxt.cycles    = (req.form == tbl_pkg::FORM_ZERO) ? tbl_pkg::ZERO_CYC_MEM : tbl_pkg::SIMM_CYC_MEM;
					end
					default: resp_nxt.illegal = 1'b1;
				endcase
			end
			tbl_pkg::FORM_SHORT_AREG_IMM: begin
				resp_nxt.size_word = (req.size == tbl_pkg::SIZE_AREG_WORD);
				resp_nxt.dst_class = tbl_pkg::OPC_ADDR_REG;
				resp_nxt.dst_code  = {3'h2, req.dst_code[0]};
				resp_nxt.bytes     = tbl_pkg::SAREG_BYTES + {3'h0, resp_nxt.size_word};
				resp_nxt.cycles    = tbl_pkg::SAREG_CYC + {3'h0, resp_nxt.size_word};
			end
			tbl_pkg::FORM_SHORT_AREG_LD, tbl_pkg::FORM_SHORT_ACC_LD: begin
				resp_nxt.size_word = 1'b0;
				resp_nxt.dst_class = (req.form == tbl_pkg::FORM_SHORT_AREG_LD) ? tbl_pkg::OPC_ADDR_REG : tbl_pkg::OPC_DATA_REG;
				resp_nxt.dst_code  = {(req.form == tbl_pkg::FORM_SHORT_AREG_LD) ? 3'h2 : 3'h0, req.dst_code[0]};
				unique case (ssrc)
					tbl_pkg::SSRC_ACC: begin
						resp_nxt.src_class = tbl_pkg::OPC_DATA_REG;
						resp_nxt.bytes     = tbl_pkg::SLD_BYTES;
						resp_nxt.cycles    = tbl_pkg::SLD_CYC_REG;
					end
					default: begin
						resp_nxt.src_class = (ssrc == tbl_pkg::SSRC_DIRECT_16BIT_OPERAND) ? tbl_pkg::OPC_DIRECT_16BIT_OPERAND : tbl_pkg::OPC_DSP8;
						resp_nxt.bytes     = tbl_pkg::SLD_BYTES
							+ ((ssrc == tbl_pkg::SSRC_DIRECT_16BIT_OPERAND) ? tbl_pkg::EXT_DSP16 : tbl_pkg::EXT_DSP8);
						resp_nxt.cycles    = tbl_pkg::SLD_CYC_MEM;
					end
				endcase
			end
			tbl_pkg::FORM_SHORT_ACC_ST: begin
				resp_nxt.size_word = 1'b0;
				resp_nxt.src_class = tbl_pkg::OPC_DATA_REG;
				resp_nxt.src_code  = {3'h0, req.src_code[0]};
				resp_nxt.cycles    = tbl_pkg::SST_CYC;
				if (ssrc_dst_zero(req.dst_code[1:0]))
					resp_nxt.illegal = 1'b1;
				resp_nxt.dst_class = (req.dst_code[1:0] == tbl_pkg::SSRC_DIRECT_16BIT_OPERAND) ? tbl_pkg::OPC_DIRECT_16BIT_OPERAND : tbl_pkg::OPC_DSP8;
				resp_nxt.bytes     = tbl_pkg::SST_BYTES
					+ ((req.dst_code[1:0] == tbl_pkg::SSRC_DIRECT_16BIT_OPERAND) ? tbl_pkg::EXT_DSP16 : tbl_pkg::EXT_DSP8);
			end
			tbl_pkg::FORM_SP_LD: begin
				resp_nxt.dst_class = dst_cls;
				resp_nxt.src_class = tbl_pkg::OPC_DSP8;
				resp_nxt.bytes     = tbl_pkg::SPL_BYTES + dst_ext;
				resp_nxt.cycles    = dst_reg ? tbl_pkg::SPL_CYC_REG : tbl_pkg::SPL_CYC_MEM;
			end
			tbl_pkg::FORM_SP_ST: begin
				resp_nxt.src_class = src_cls;
				resp_nxt.dst_class = tbl_pkg::OPC_DSP8;
				resp_nxt.bytes     = tbl_pkg::SPS_BYTES + src_ext;
				resp_nxt.cycles    = src_reg ? tbl_pkg::SPS_CYC_REG : tbl_pkg::SPS_CYC_MEM;
			end
			tbl_pkg::FORM_GEN_XFER: begin
				resp_nxt.src_class = src_cls;
				resp_nxt.dst_class = dst_cls;
				resp_nxt.bytes     = tbl_pkg::GX_BYTES + src_ext + dst_ext;
				resp_nxt.cycles    = src_reg ? tbl_pkg::GX_CYC_REG : tbl_pkg::GX_CYC_MEM;
			end
			default: resp_nxt.illegal = 1'b1;
		endcase
		if (!req.valid)
			resp_nxt = '0;
	end

	function automatic logic ssrc_dst_zero(input logic [1:0] c);
		ssrc_dst_zero = (c == 2'h0);
	endfunction : ssrc_dst_zero

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			resp_r <= '0;
		else
			resp_r <= resp_nxt;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_base_words;
		word_valid && word_in == tbl_pkg::BL_WORD1 ##1 word_valid && word_in[15:12] == 4'h0 && word_in[7:0] == 8'h00
			##1 word_valid && word_in == tbl_pkg::BL_WORD3 ##1 word_valid;
	endsequence

	chk_base_value: assert property (@(posedge clk) disable iff (!reset_n)
		s_base_words |=> base_done_r && interrupt_table_base_r == {$past(word_upper, 3), $past(word_in)})
		else $error("base value not assembled from the two fields");

	chk_base_cost: assert property (@(posedge clk) disable iff (!reset_n)
		s_base_words |=> base_bytes_r == 4'h8 && base_cycles_r == 4'h4)
		else $error("base load cost wrong");

	chk_resp_follows: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_GEN_IMM && req.dst_code < 4'h6
			|=> resp_r.valid && resp_r.cycles == 4'h2 && resp_r.bytes == 4'h3 + {3'h0, $past(req.size)})
		else $error("generic immediate register cost wrong");

	chk_gimm_word_abs: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_GEN_IMM && req.dst_code == 4'hf && req.size
			|=> resp_r.bytes == 4'h6 && resp_r.cycles == 4'h3)
		else $error("word immediate extra byte missing");

	chk_quick_sign: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_QUICK && req.size && req.quick_immediate_field == 4'h8
			|=> resp_r.imm == 16'hfff8)
		else $error("quick immediate not sign extended");

	chk_short_illegal: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_SHORT_IMM && req.dst_code[2:0] < 3'h3 |=> resp_r.illegal)
		else $error("bad short destination accepted");

	chk_areg_word: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_SHORT_AREG_IMM && !req.size
			|=> resp_r.bytes == 4'h3 && resp_r.cycles == 4'h2 && resp_r.size_word)
		else $error("inverted size bit mishandled");

	chk_zero_abs: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_ZERO && req.dst_code[2:0] == 3'h7
			|=> resp_r.bytes == 4'h3 && resp_r.cycles == 4'h2 && resp_r.imm == 16'h0000)
		else $error("zero form direct cost wrong");

	chk_sp_store: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_SP_ST && req.src_code == 4'hc
			|=> resp_r.bytes == 4'h5 && resp_r.cycles == 4'h4)
		else $error("stack store cost wrong");

	chk_xfer_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.form == tbl_pkg::FORM_GEN_XFER && req.src_code == 4'h6 |=> resp_r.cycles == 4'h3)
		else $error("transfer cycles wrong");

endmodule : tbl_decoder

/* src/tbl_pkg.sv */
// Shared types and constants for the transfer and base-load decoder
package tbl_pkg;

	// ----------------------------------------
	// Forms and operand classes
	// ----------------------------------------
	typedef enum logic [3:0] {
		FORM_GEN_IMM,
		FORM_QUICK,
		FORM_SHORT_IMM,
		FORM_SHORT_AREG_IMM,
		FORM_ZERO,
		FORM_SHORT_AREG_LD,
		FORM_SHORT_ACC_ST,
		FORM_SHORT_ACC_LD,
		FORM_SP_LD,
		FORM_SP_ST,
		FORM_GEN_XFER
	} tbl_form_t;

	typedef enum logic [2:0] {
		OPC_DATA_REG,
		OPC_ADDR_REG,
		OPC_INDIRECT,
		OPC_DSP8,
		OPC_DSP16,
		OPC_DSP16_SB,
		OPC_DIRECT_16BIT_OPERAND,
		OPC_NONE
	} tbl_opclass_t;

	typedef struct packed {
		logic      valid;
		tbl_form_t form;
		logic      size;
		logic [3:0] dst_code;
		logic [3:0] src_code;
		logic [3:0] quick_immediate_field;
	} tbl_req_t;

	typedef struct packed {
		logic         valid;
		logic         illegal;
		logic [3:0]   bytes;
		logic [3:0]   cycles;
		tbl_opclass_t dst_class;
		tbl_opclass_t src_class;
		logic [3:0]   dst_code;
		logic [3:0]   src_code;
		logic         size_word;
		logic [15:0]  imm;
	} tbl_resp_t;

	// ----------------------------------------
	// Base-load sequence
	// ----------------------------------------
	localparam logic [15:0] BL_WORD1      = 16'heb20;
	localparam logic [15:0] BL_WORD3      = 16'heb10;
	localparam int          BL_UPPER_LSB  = 8;
	localparam int          BL_UPPER_W    = 4;
	localparam logic [3:0]  BL_BYTES      = 4'h8;
	localparam logic [3:0]  BL_CYCLES     = 4'h4;

	// ----------------------------------------
	// Size bits and short codes
	// ----------------------------------------
	localparam logic        SIZE_WORD     = 1'b1;
	localparam logic        SIZE_AREG_WORD = 1'b0;
	localparam logic [2:0]  SDST_ACC_HIGH = 3'h3;
	localparam logic [2:0]  SDST_ACC_LOW  = 3'h4;
	localparam logic [2:0]  SDST_SB_DSP8  = 3'h5;
	localparam logic [2:0]  SDST_FB_DSP8  = 3'h6;
	localparam logic [2:0]  SDST_DIRECT_16BIT_OPERAND    = 3'h7;
	localparam logic [1:0]  SSRC_ACC      = 2'h0;
	localparam logic [1:0]  SSRC_DIRECT_16BIT_OPERAND    = 2'h3;

	// ----------------------------------------
	// Byte and cycle figures
	// ----------------------------------------
	localparam logic [3:0]  GIMM_BYTES    = 4'h3;
	localparam logic [3:0]  GIMM_CYC_REG  = 4'h2;
	localparam logic [3:0]  GIMM_CYC_MEM  = 4'h3;
	localparam logic [3:0]  QUICK_BYTES   = 4'h2;
	localparam logic [3:0]  QUICK_CYC_REG = 4'h1;
	localparam logic [3:0]  QUICK_CYC_MEM = 4'h2;
	localparam logic [3:0]  SIMM_BYTES    = 4'h2;
	localparam logic [3:0]  SIMM_CYC_REG  = 4'h1;
	localparam logic [3:0]  SIMM_CYC_MEM  = 4'h2;
	localparam logic [3:0]  SAREG_BYTES   = 4'h2;
	localparam logic [3:0]  SAREG_CYC     = 4'h1;
	localparam logic [3:0]  ZERO_BYTES    = 4'h1;
	localparam logic [3:0]  ZERO_CYC_REG  = 4'h1;
	localparam logic [3:0]  ZERO_CYC_MEM  = 4'h2;
	localparam logic [3:0]  SLD_BYTES     = 4'h1;
	localparam logic [3:0]  SLD_CYC_REG   = 4'h2;
	localparam logic [3:0]  SLD_CYC_MEM   = 4'h3;
	localparam logic [3:0]  SST_BYTES     = 4'h1;
	localparam logic [3:0]  SST_CYC       = 4'h2;
	localparam logic [3:0]  SPL_BYTES     = 4'h3;
	localparam logic [3:0]  SPL_CYC_REG   = 4'h2;
	localparam logic [3:0]  SPL_CYC_MEM   = 4'h3;
	localparam logic [3:0]  SPS_BYTES     = 4'h3;
	localparam logic [3:0]  SPS_CYC_REG   = 4'h3;
	localparam logic [3:0]  SPS_CYC_MEM   = 4'h4;
	localparam logic [3:0]  GX_BYTES      = 4'h2;
	localparam logic [3:0]  GX_CYC_REG    = 4'h2;
	localparam logic [3:0]  GX_CYC_MEM    = 4'h3;
	localparam logic [3:0]  EXT_DSP8      = 4'h1;
	localparam logic [3:0]  EXT_DSP16     = 4'h2;

endpackage : tbl_pkg

/* src/tbl_opclass.sv */
// Classifier for the 4-bit generic operand code
`timescale 1ns/1ps
module tbl_opclass (
	input  wire logic [3:0]           code,
	output tbl_pkg::tbl_opclass_t     op_class,
	output logic      [3:0]           ext_bytes,
	output logic                      is_reg
);

	// ----------------------------------------
	// Code to class
	// ----------------------------------------
	always_comb begin
		ext_bytes = 4'h0;
		is_reg    = 1'b0;
		unique case (code) inside
			[4'h0:4'h3]: begin
				op_class = tbl_pkg::OPC_DATA_REG;
				is_reg   = 1'b1;
			end
			[4'h4:4'h5]: begin
				op_class = tbl_pkg::OPC_ADDR_REG;
				is_reg   = 1'b1;
			end
			[4'h6:4'h7]: op_class = tbl_pkg::OPC_INDIRECT;
			[4'h8:4'hb]: begin
				op_class  = tbl_pkg::OPC_DSP8;
				ext_bytes = tbl_pkg::EXT_DSP8;
			end
			[4'hc:4'hd]: begin
				op_class  = tbl_pkg::OPC_DSP16;
				ext_bytes = tbl_pkg::EXT_DSP16;
			end
			4'he: begin
				op_class  = tbl_pkg::OPC_DSP16_SB;
				ext_bytes = tbl_pkg::EXT_DSP16;
			end
			4'hf: begin
				op_class  = tbl_pkg::OPC_DIRECT_16BIT_OPERAND;
				ext_bytes = tbl_pkg::EXT_DSP16;
			end
		endcase
	end

endmodule : tbl_opclass

/* tb/tbl_fetch_model.sv */
// Fetch-side model streaming the table-base load word sequence
`timescale 1ns/1ps
module tbl_fetch_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic        slow,
	input  wire logic        corrupt,
	input  wire logic [3:0]  upper,
	input  wire logic [15:0] lower,
	output logic             word_valid,
	output logic      [15:0] word_in,
	output logic             busy
);
	logic [1:0] step_r;
	logic       gap_r;

	// ----------------------------------------
	// Word stream
	// ----------------------------------------
	function automatic logic [15:0] word_at(input logic [1:0] s);
		case (s)
			2'h0: word_at = tbl_pkg::BL_WORD1;
			2'h1: word_at = {4'h0, upper, 8'h00};
			2'h2: word_at = corrupt ? 16'h1234 : tbl_pkg::BL_WORD3;
			default: word_at = lower;
		endcase
	endfunction : word_at

	// Idle word lines toggle, so a stale word never passes for a fresh one
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			step_r     <= 2'h0;
			gap_r      <= 1'b0;
			busy       <= 1'b0;
			word_valid <= 1'b0;
			word_in    <= 16'h0;
		end else begin
			word_valid <= 1'b0;
			word_in    <= ~word_in;
			if (!busy && start) begin
				busy   <= 1'b1;
				step_r <= 2'h0;
				gap_r  <= 1'b0;
			end else if (busy) begin
				if (slow && !gap_r) begin
					gap_r <= 1'b1;
				end else begin
					word_valid <= 1'b1;
					word_in    <= word_at(step_r);
					gap_r      <= 1'b0;
					step_r     <= step_r + 2'h1;
					if (step_r == 2'h3) begin
						busy <= 1'b0;
					end
				end
			end
		end
	end
endmodule : tbl_fetch_model

/* tb/transfer_and_base_load_decoder_bench.sv */
// Self-checking bench for the transfer and base-load decoder
`timescale 1ns/1ps
`define CHK(got, want) begin check_count++; if ((got) !== (want)) begin mismatches++; \
	$display("ERROR t=%0t value mismatch got %h exp %h", $time, got, want); end end
module transfer_and_base_load_decoder_bench;
	logic                clk;
	logic                reset_n;
	tbl_pkg::tbl_req_t   req;
	tbl_pkg::tbl_resp_t  resp_r;
	logic                base_done_r;
	logic [19:0]         interrupt_table_base_r;
	logic [3:0]          base_bytes_r;
	logic [3:0]          base_cycles_r;
	logic                word_valid;
	logic [15:0]         word_in;
	logic                m_start;
	logic                m_slow;
	logic                m_bad;
	logic                m_busy;
	logic [3:0]          m_up;
	logic [15:0]         m_lo;
	int                  mismatches;
	int                  check_count;
	int                  cycles;

	tbl_decoder tbl_decoder_i (.clk(clk), .reset_n(reset_n), .word_valid(word_valid), .word_in(word_in),
		.req(req), .resp_r(resp_r), .base_done_r(base_done_r), .interrupt_table_base_r(interrupt_table_base_r),
		.base_bytes_r(base_bytes_r), .base_cycles_r(base_cycles_r));
	tbl_fetch_model tbl_fetch_model_i (.clk(clk), .reset_n(reset_n), .start(m_start), .slow(m_slow),
		.corrupt(m_bad), .upper(m_up), .lower(m_lo), .word_valid(word_valid), .word_in(word_in), .busy(m_busy));

	// ----------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done();
		if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("ERROR t=%0t timeout", $time);
			test_done();
		end
	end

	// ----------------------------------------
	// Expected figures
	// ----------------------------------------
	function automatic logic [3:0] ext(input logic [3:0] c);
		ext = (c >= 4'hc) ? 4'h2 : (c >= 4'h8) ? 4'h1 : 4'h0;
	endfunction : ext

	function automatic tbl_pkg::tbl_opclass_t cls(input logic [3:0] c);
		if (c < 4'h4) cls = tbl_pkg::OPC_DATA_REG;
		else if (c < 4'h6) cls = tbl_pkg::OPC_ADDR_REG;
		else if (c < 4'h8) cls = tbl_pkg::OPC_INDIRECT;
		else if (c < 4'hc) cls = tbl_pkg::OPC_DSP8;
		else if (c < 4'he) cls = tbl_pkg::OPC_DSP16;
		else if (c == 4'he) cls = tbl_pkg::OPC_DSP16_SB;
		else cls = tbl_pkg::OPC_DIRECT_16BIT_OPERAND;
	endfunction : cls

	function automatic void expect_of(input tbl_pkg::tbl_form_t f, input logic sz, input logic [3:0] d, s,
		output logic [3:0] b, c, output logic ill);
		ill = 1'b0;
		b = 4'h0;
		c = 4'h0;
		case (f)
			tbl_pkg::FORM_GEN_IMM: begin b = 4'h3 + ext(d) + {3'h0, sz}; c = (d < 4'h6) ? 4'h2 : 4'h3; end
			tbl_pkg::FORM_QUICK: begin b = 4'h2 + ext(d); c = (d < 4'h6) ? 4'h1 : 4'h2; end
			tbl_pkg::FORM_SHORT_IMM, tbl_pkg::FORM_ZERO: begin
				case (d[2:0])
					3'h3, 3'h4: begin b = 4'h2; c = 4'h1; end
					3'h5, 3'h6: begin b = 4'h3; c = 4'h2; end
					3'h7: begin b = 4'h4; c = 4'h2; end
					default: ill = 1'b1;
				endcase
				if (f == tbl_pkg::FORM_ZERO) b = b - 4'h1;
			end
			tbl_pkg::FORM_SHORT_AREG_IMM: begin b = sz ? 4'h2 : 4'h3; c = sz ? 4'h1 : 4'h2; end
			tbl_pkg::FORM_SHORT_AREG_LD, tbl_pkg::FORM_SHORT_ACC_LD: begin
				b = (s[1:0] == 2'h3) ? 4'h3 : (s[1:0] == 2'h0) ? 4'h1 : 4'h2;
				c = (s[1:0] == 2'h0) ? 4'h2 : 4'h3;
			end
			tbl_pkg::FORM_SHORT_ACC_ST: begin
				ill = (d[1:0] == 2'h0);
				b = (d[1:0] == 2'h3) ? 4'h3 : 4'h2;
				c = 4'h2;
			end
			tbl_pkg::FORM_SP_LD: begin b = 4'h3 + ext(d); c = (d < 4'h6) ? 4'h2 : 4'h3; end
			tbl_pkg::FORM_SP_ST: begin b = 4'h3 + ext(s); c = (s < 4'h6) ? 4'h3 : 4'h4; end
			default: begin b = 4'h2 + ext(s) + ext(d); c = (s < 4'h6) ? 4'h2 : 4'h3; end
		endcase
	endfunction : expect_of

	// ----------------------------------------
	// Request driver: one request per cycle, back to back
	// ----------------------------------------
	task automatic req_chk(input tbl_pkg::tbl_form_t f, input logic sz, input logic [3:0] d, s, i);
		logic [3:0] eb;
		logic [3:0] ec;
		logic       ill;
		expect_of(f, sz, d, s, eb, ec, ill);
		req <= '{valid: 1'b1, form: f, size: sz, dst_code: d, src_code: s, quick_immediate_field: i};
		@(negedge clk);
		`CHK(resp_r.valid, 1'b1)
		`CHK(resp_r.illegal, ill)
		if (!ill) begin
			`CHK(resp_r.bytes, eb)
			`CHK(resp_r.cycles, ec)
		end
		if (f == tbl_pkg::FORM_GEN_IMM || f == tbl_pkg::FORM_QUICK || f == tbl_pkg::FORM_SP_LD) begin
			`CHK(resp_r.dst_class, cls(d))
			`CHK(resp_r.size_word, sz)
		end
		if (f == tbl_pkg::FORM_GEN_XFER || f == tbl_pkg::FORM_SP_ST) `CHK(resp_r.src_class, cls(s))
	endtask : req_chk

	task automatic req_idle();
		req.valid <= 1'b0;
		@(negedge clk);
		`CHK(resp_r.valid, 1'b0)
	endtask : req_idle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_generic();
		for (int k = 0; k < 32; k++) begin
			req_chk(tbl_pkg::FORM_GEN_IMM, k[4], k[3:0], 4'h0, 4'h0);
			req_chk(tbl_pkg::FORM_SP_LD, k[4], k[3:0], 4'h0, 4'h0);
			req_chk(tbl_pkg::FORM_SP_ST, k[4], 4'h0, k[3:0], 4'h0);
			req_chk(tbl_pkg::FORM_GEN_XFER, k[4], ~k[3:0], k[3:0], 4'h0);
		end
		req_idle();
	endtask : t_generic

	task automatic t_quick();
		logic [15:0] sx;
		for (int k = 0; k < 32; k++) begin
			sx = {{12{k[3]}}, k[3:0]};
			req_chk(tbl_pkg::FORM_QUICK, k[4], k[3:0], 4'h0, k[3:0]);
			`CHK(resp_r.imm, k[4] ? sx : {8'h00, sx[7:0]})
		end
		req_idle();
	endtask : t_quick

	task automatic t_short();
		for (int k = 0; k < 8; k++) begin
			req_chk(tbl_pkg::FORM_SHORT_IMM, 1'b0, k[3:0], 4'h0, 4'h0);
			req_chk(tbl_pkg::FORM_ZERO, 1'b0, k[3:0], 4'h0, 4'h0);
			req_chk(tbl_pkg::FORM_SHORT_AREG_LD, 1'b0, {3'h0, k[2]}, {2'h0, k[1:0]}, 4'h0);
			`CHK(resp_r.dst_code, {3'h2, k[2]})
			req_chk(tbl_pkg::FORM_SHORT_ACC_LD, 1'b0, {3'h0, k[2]}, {2'h0, k[1:0]}, 4'h0);
			req_chk(tbl_pkg::FORM_SHORT_ACC_ST, 1'b0, {2'h0, k[1:0]}, {3'h0, k[2]}, 4'h0);
		end
		for (int k = 0; k < 4; k++) begin
			req_chk(tbl_pkg::FORM_SHORT_AREG_IMM, k[1], {3'h0, k[0]}, 4'h0, 4'h0);
			`CHK(resp_r.size_word, ~k[1])
			`CHK(resp_r.dst_code, {3'h2, k[0]})
		end
		req_idle();
	endtask : t_short

	task automatic t_base(input logic sl, input logic bad, input logic [3:0] up, input logic [15:0] lo);
		logic [19:0] base_prev;
		int          n;
		base_prev = interrupt_table_base_r;
		m_slow <= sl;
		m_bad <= bad;
		m_up <= up;
		m_lo <= lo;
		m_start <= 1'b1;
		@(negedge clk);
		m_start <= 1'b0;
		n = 0;
		while (base_done_r !== 1'b1 && n < 16) begin
			@(negedge clk);
			n++;
		end
		if (bad) begin
			`CHK(base_done_r, 1'b0)
			`CHK(interrupt_table_base_r, base_prev)
		end else begin
			if (!sl) `CHK(n, 5)
			`CHK(interrupt_table_base_r, {up, lo})
			`CHK(base_bytes_r, 4'h8)
			`CHK(base_cycles_r, 4'h4)
			@(negedge clk);
			`CHK(base_done_r, 1'b0)
		end
	endtask : t_base

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		mismatches = 0;
		check_count = 0;
		cycles = 0;
		reset_n = 1'b0;
		req = '0;
		m_start = 1'b0;
		m_slow = 1'b0;
		m_bad = 1'b0;
		m_up = 4'h0;
		m_lo = 16'h0;
		repeat (10) @(negedge clk);
		`CHK(resp_r.valid, 1'b0)
		`CHK(base_bytes_r, 4'h0)
		`CHK(base_done_r, 1'b0)
		`CHK(interrupt_table_base_r, 20'h00000)
		reset_n <= 1'b1;
		@(negedge clk);
		t_base(1'b0, 1'b0, 4'ha, 16'h5c3e);
		t_base(1'b0, 1'b1, 4'h3, 16'h0001);
		t_base(1'b1, 1'b0, 4'hf, 16'hffff);
		t_generic();
		t_quick();
		t_short();
		test_done();
	end
endmodule : transfer_and_base_load_decoder_bench
